// *** shared/zea_pkg.sv ***
// constants for the zone egress alarm controller
// Functional notes
// - lock while tag present and door closed
// - release lock after relock delay
// - egress alarm on tag with door/motion
// - egress alarm latches until cleared
// - clear needs no tag, door shut, code
// - code starts escort: unlock, silence, pass
// - loiter alarm after tag lingers
// - door ajar alarm after door held open
// - ajar clears: door shut, code or strap
// - loiter clears: no tag, code or strap
// - elevator call inhibited while tag present
// - elevator door held open until code
// - hallway tag plus motion sounds alarm
// - supervisory alarm follows fault condition
// - code silences receiver fault one interval
// - band alarm on tag band report
package zea_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS = 1000000000;
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int SEC_W = 7;
   localparam logic [SEC_W-1:0] ESCORT_MAX_S = 7'd98;
   localparam logic [SEC_W-1:0] TMR_MIN_S = 7'd10;
   localparam logic [SEC_W-1:0] TMR_MAX_S = 7'd110;
   // ****************************************
   // register map and reset values
   // ****************************************
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_RELOCK = 4'h1;
   localparam logic [3:0] A_ESCORT = 4'h2;
   localparam logic [3:0] A_LOITER = 4'h3;
   localparam logic [3:0] A_AJAR = 4'h4;
   localparam logic [3:0] A_SUPV = 4'h5;
   localparam logic [3:0] A_IRQ_STAT = 4'h6;
   localparam logic [3:0] A_IRQ_MASK = 4'h7;
   localparam logic [3:0] A_STATE = 4'h8;
   localparam logic [7:0] RST_CTRL = 8'h04;
   localparam logic [SEC_W-1:0] RST_RELOCK = 7'd5;
   localparam logic [SEC_W-1:0] RST_ESCORT = 7'd30;
   localparam logic [SEC_W-1:0] RST_LOITER = 7'd15;
   localparam logic [SEC_W-1:0] RST_AJAR = 7'd15;
   localparam logic [SEC_W-1:0] RST_SUPV = 7'd60;
   // ctrl fields
   localparam int C_MODE = 0;
   localparam int C_LOCK = 2;
   localparam int C_LOITER = 3;
   localparam int C_AJAR = 4;
   localparam int C_ELEV = 5;
   localparam int C_HLOCK = 6;
   localparam logic [1:0] M_DOOR = 2'h0;
   localparam logic [1:0] M_ELEV = 2'h1;
   localparam logic [1:0] M_HALL = 2'h2;
   // alarm / status bit positions
   localparam int N_ALM = 6;
   localparam int B_EGR = 0;
   localparam int B_LOI = 1;
   localparam int B_AJR = 2;
   localparam int B_SUP = 3;
   localparam int B_BND = 4;
   localparam int B_ELV = 5;
   // timer slots
   localparam int N_TMR = 5;
   localparam int T_RELOCK = 0;
   localparam int T_ESCORT = 1;
   localparam int T_LOITER = 2;
   localparam int T_AJAR = 3;
   localparam int T_SUPV = 4;
endpackage

// *** shared/zea_tmr_if.sv ***
// seconds timer hookup
`timescale 1ns/1ps
interface zea_tmr_if;
   logic arm;
   logic [zea_pkg::SEC_W-1:0] load;
   logic done;
   modport ctl (output arm, output load, input done);
   modport tmr (input arm, input load, output done);
endinterface

// *** logic/zea_timer.sv ***
// seconds down-counter, reloads whenever disarmed
`timescale 1ns/1ps
module zea_timer (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_tick,
   zea_tmr_if.tmr bus
);
   logic [zea_pkg::SEC_W-1:0] cnt;

   // first second may be short: tick phase is free running
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= '0;
         bus.done <= 1'b0;
      end else if (!bus.arm) begin
         cnt <= bus.load;
         bus.done <= 1'b0;
      end else if (cnt == '0) begin
         bus.done <= 1'b1;
      end else if (i_tick) begin
         cnt <= cnt - 1'b1;
      end
   end
endmodule // zea_timer

// *** logic/zea_ctrl.sv ***
// zone egress alarm controller top
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module zea_ctrl #(
   parameter int TICK_CYCLES = zea_pkg::TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_tag_present,
   input wire logic i_door_open,
   input wire logic i_motion_detector,
   input wire logic i_lock_obstructed,
   input wire logic i_elev_door_open,
   input wire logic i_key_valid,
   input wire logic i_auto_clear_strap,
   input wire logic i_fault_wiring,
   input wire logic i_fault_antenna,
   input wire logic i_fault_rx,
   input wire logic i_band_report,
   output logic o_lock,
   output logic o_call_inhibit,
   output logic o_hold_door,
   output logic o_audible,
   output logic o_visual,
   output logic o_egress_alarm,
   output logic o_loiter_alarm,
   output logic o_ajar_alarm,
   output logic o_super_alarm,
   output logic o_band_alarm,
   output logic o_irq
);
   localparam int SW = zea_pkg::SEC_W;
   localparam int TW = $clog2(TICK_CYCLES);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] ctrl;
   logic [SW-1:0] cfg_relock, cfg_escort, cfg_loiter, cfg_ajar, cfg_supv;
   logic [zea_pkg::N_ALM-1:0] irq_stat, irq_mask, alm, alm_q, ev;
   logic [7:0] state_rd;
   logic [1:0] mode;

   assign mode = ctrl[zea_pkg::C_MODE +: 2];

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl <= zea_pkg::RST_CTRL;
         cfg_relock <= zea_pkg::RST_RELOCK;
         cfg_escort <= zea_pkg::RST_ESCORT;
         cfg_loiter <= zea_pkg::RST_LOITER;
         cfg_ajar <= zea_pkg::RST_AJAR;
         cfg_supv <= zea_pkg::RST_SUPV;
         irq_mask <= '0;
      end else if (i_wr) begin
         case (i_addr)
            zea_pkg::A_CTRL: ctrl <= i_wdata;
            zea_pkg::A_RELOCK: cfg_relock <= i_wdata[SW-1:0];
            zea_pkg::A_ESCORT: cfg_escort <= i_wdata[SW-1:0];
            zea_pkg::A_LOITER: cfg_loiter <= i_wdata[SW-1:0];
            zea_pkg::A_AJAR: cfg_ajar <= i_wdata[SW-1:0];
            zea_pkg::A_SUPV: cfg_supv <= i_wdata[SW-1:0];
            zea_pkg::A_IRQ_MASK: irq_mask <= i_wdata[zea_pkg::N_ALM-1:0];
            default: ;
         endcase
      end
   end

   // set wins over a write-one clear in the same cycle
   assign ev = alm & ~alm_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat <= '0;
         alm_q <= '0;
         o_irq <= 1'b0;
      end else begin
         alm_q <= alm;
         o_irq <= |(irq_stat & irq_mask);
         if (i_wr && i_addr == zea_pkg::A_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~i_wdata[zea_pkg::N_ALM-1:0]) | ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         case (i_addr)
            zea_pkg::A_CTRL: o_rdata <= ctrl;
            zea_pkg::A_RELOCK: o_rdata <= {1'b0, cfg_relock};
            zea_pkg::A_ESCORT: o_rdata <= {1'b0, cfg_escort};
            zea_pkg::A_LOITER: o_rdata <= {1'b0, cfg_loiter};
            zea_pkg::A_AJAR: o_rdata <= {1'b0, cfg_ajar};
            zea_pkg::A_SUPV: o_rdata <= {1'b0, cfg_supv};
            zea_pkg::A_IRQ_STAT: o_rdata <= {2'b00, irq_stat};
            zea_pkg::A_IRQ_MASK: o_rdata <= {2'b00, irq_mask};
            zea_pkg::A_STATE: o_rdata <= state_rd;
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

   // ****************************************
   // one-second tick
   // ****************************************
   logic [TW-1:0] tick_cnt;
   logic tick;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // ****************************************
   // timers
   // ****************************************
   function automatic logic [SW-1:0] clamp(input logic [SW-1:0] v, input logic [SW-1:0] hi);
      clamp = (v < zea_pkg::TMR_MIN_S) ? zea_pkg::TMR_MIN_S : ((v > hi) ? hi : v);
   endfunction

   logic [zea_pkg::N_TMR-1:0] arm, done;
   logic [SW-1:0] load [zea_pkg::N_TMR];
   logic lock_on, esc_on, rx_sil, egress, loiter, ajar, elev_hold;

   assign arm[zea_pkg::T_RELOCK] = lock_on & ~i_tag_present;
   assign arm[zea_pkg::T_ESCORT] = esc_on & ~i_key_valid;
   assign arm[zea_pkg::T_LOITER] = ctrl[zea_pkg::C_LOITER] & i_tag_present;
   assign arm[zea_pkg::T_AJAR] = ctrl[zea_pkg::C_AJAR] & i_door_open;
   assign arm[zea_pkg::T_SUPV] = rx_sil & ~(i_key_valid & i_fault_rx);
   assign load[zea_pkg::T_RELOCK] = cfg_relock;
   assign load[zea_pkg::T_ESCORT] = (cfg_escort > zea_pkg::ESCORT_MAX_S) ? zea_pkg::ESCORT_MAX_S : cfg_escort;
   assign load[zea_pkg::T_LOITER] = clamp(cfg_loiter, zea_pkg::TMR_MAX_S);
   // zero means immediate ajar alarm
   assign load[zea_pkg::T_AJAR] = (cfg_ajar == '0) ? '0 : clamp(cfg_ajar, zea_pkg::TMR_MAX_S);
   assign load[zea_pkg::T_SUPV] = cfg_supv;

   zea_tmr_if tif [zea_pkg::N_TMR] ();

   genvar gi;
   generate
      for (gi = 0; gi < zea_pkg::N_TMR; gi++) begin : g_tmr
         assign tif[gi].arm = arm[gi];
         assign tif[gi].load = load[gi];
         assign done[gi] = tif[gi].done;
         zea_timer u_tmr (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_tick(tick),
            .bus(tif[gi])
         );
      end
   endgenerate

   // ****************************************
   // zone logic
   // ****************************************
   logic engage, egr_set, loi_set, ajr_set, elv_set, fault_any;

   assign engage = (ctrl[zea_pkg::C_LOCK] && mode == zea_pkg::M_DOOR && i_tag_present
                    && !i_door_open && !i_lock_obstructed)
                   || (ctrl[zea_pkg::C_HLOCK] && mode == zea_pkg::M_HALL
                       && i_tag_present && i_motion_detector);
   // escort lets the tag pass, so no new egress or elevator hold alarm arms during it
   assign egr_set = i_tag_present && (i_door_open || i_motion_detector) && !esc_on;
   assign loi_set = ctrl[zea_pkg::C_LOITER] && i_tag_present && done[zea_pkg::T_LOITER];
   assign ajr_set = ctrl[zea_pkg::C_AJAR] && i_door_open && done[zea_pkg::T_AJAR];
   assign elv_set = mode == zea_pkg::M_ELEV && i_tag_present && i_elev_door_open && !esc_on;
   assign fault_any = i_fault_wiring | i_fault_antenna | (i_fault_rx & ~rx_sil);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         esc_on <= 1'b0;
      end else if (i_key_valid) begin
         esc_on <= 1'b1;
      end else if (done[zea_pkg::T_ESCORT]) begin
         esc_on <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lock_on <= 1'b0;
      end else if (esc_on) begin
         lock_on <= 1'b0;
      end else if (engage) begin
         lock_on <= 1'b1;
      end else if (lock_on && !i_tag_present && done[zea_pkg::T_RELOCK]) begin
         lock_on <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         egress <= 1'b0;
      end else if (egr_set) begin
         egress <= 1'b1;
      end else if (!i_tag_present && !i_door_open && i_key_valid) begin
         egress <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         loiter <= 1'b0;
      end else if (loi_set) begin
         loiter <= 1'b1;
      end else if (!i_tag_present && (i_key_valid || i_auto_clear_strap)) begin
         loiter <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ajar <= 1'b0;
      end else if (ajr_set) begin
         ajar <= 1'b1;
      end else if (!i_door_open && (i_key_valid || i_auto_clear_strap)) begin
         ajar <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         elev_hold <= 1'b0;
      end else if (elv_set) begin
         elev_hold <= 1'b1;
      end else if (i_key_valid) begin
         elev_hold <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_sil <= 1'b0;
      end else if (i_key_valid && i_fault_rx) begin
         rx_sil <= 1'b1;
      end else if (done[zea_pkg::T_SUPV]) begin
         rx_sil <= 1'b0;
      end
   end

   assign alm = {elev_hold, o_band_alarm, o_super_alarm, ajar, loiter, egress};
   assign state_rd = {esc_on, lock_on, alm};

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lock <= 1'b0;
         o_call_inhibit <= 1'b0;
         o_hold_door <= 1'b0;
         o_audible <= 1'b0;
         o_visual <= 1'b0;
         o_egress_alarm <= 1'b0;
         o_loiter_alarm <= 1'b0;
         o_ajar_alarm <= 1'b0;
         o_super_alarm <= 1'b0;
         o_band_alarm <= 1'b0;
      end else begin
         o_lock <= lock_on;
         o_call_inhibit <= mode == zea_pkg::M_ELEV && ctrl[zea_pkg::C_ELEV] && i_tag_present;
         o_hold_door <= elev_hold;
         o_audible <= (egress | loiter | ajar | elev_hold) & ~esc_on;
         o_visual <= (egress | loiter | ajar | elev_hold) & ~esc_on;
         o_egress_alarm <= egress;
         o_loiter_alarm <= loiter;
         o_ajar_alarm <= ajar;
         o_super_alarm <= fault_any;
         o_band_alarm <= i_band_report;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_lock_cond;
      ctrl[zea_pkg::C_LOCK] && mode == zea_pkg::M_DOOR && i_tag_present && !i_door_open
      && !i_lock_obstructed && !esc_on;
   endsequence
   sequence s_hall_hit;
      mode == zea_pkg::M_HALL && i_tag_present && i_motion_detector && !esc_on && !i_key_valid;
   endsequence

   sequence s_escort_quiet;
      esc_on ##1 (!o_audible && !lock_on);
   endsequence

   chk_lock_engage: assert property (s_lock_cond |=> ##1 o_lock)
      else $error("lock not engaged");
   chk_lock_hold: assert property (lock_on && i_tag_present && !esc_on |=> lock_on)
      else $error("lock dropped with tag");
   chk_relock_wait: assert property (lock_on && !done[zea_pkg::T_RELOCK] && !esc_on |=> lock_on)
      else $error("lock released early");
   chk_egress_set: assert property (egr_set |=> egress ##1 o_egress_alarm)
      else $error("egress not raised");
   chk_egress_latch: assert property (egress && (i_tag_present || i_door_open || !i_key_valid) |=> egress)
      else $error("egress dropped");
   chk_egress_clear: assert property (egress && !egr_set && !i_tag_present && !i_door_open && i_key_valid
      |=> !egress) else $error("egress not cleared");
   chk_escort_quiet: assert property (i_key_valid |=> s_escort_quiet)
      else $error("escort not active");
   chk_loiter_raise: assert property (loi_set |=> loiter ##1 o_loiter_alarm)
      else $error("loiter missed");
   chk_ajar_raise: assert property (ajr_set |=> ajar ##1 o_ajar_alarm)
      else $error("ajar missed");
   chk_ajar_keep: assert property (ajar && i_door_open |=> ajar)
      else $error("ajar cleared open");
   chk_loiter_keep: assert property (loiter && i_tag_present |=> loiter)
      else $error("loiter cleared");
   chk_call_inhibit: assert property (mode == zea_pkg::M_ELEV && ctrl[zea_pkg::C_ELEV] && i_tag_present
      |=> o_call_inhibit) else $error("call not inhibited");
   chk_elev_hold: assert property (elv_set |=> ##1 o_hold_door)
      else $error("door not held");
   chk_hall_alarm: assert property (s_hall_hit ##1 (!esc_on && !i_key_valid) |=> o_audible && o_visual)
      else $error("hallway alarm silent");
   chk_super_track: assert property (!i_fault_wiring && !i_fault_antenna && !i_fault_rx |=> !o_super_alarm)
      else $error("supervisory stuck");
   chk_rx_silence: assert property (i_key_valid && i_fault_rx ##1 (!i_fault_wiring && !i_fault_antenna)
      |=> !o_super_alarm) else $error("receiver fault not silenced");
   chk_band_follow: assert property (i_band_report |=> o_band_alarm)
      else $error("band alarm missed");
   chk_irq_level: assert property (|(irq_stat & irq_mask) |=> o_irq)
      else $error("irq not raised");
endmodule // zea_ctrl

// *** tb/zea_zone_model.sv ***
// far-side model: tag receiver, door contact, motion detector and keypad
`timescale 1ns/1ps
module zea_zone_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_tag,
   input wire logic i_door,
   input wire logic i_motion,
   input wire logic i_key_req,
   output logic o_tag_present,
   output logic o_door_open,
   output logic o_motion_detector,
   output logic o_key_valid
);
   logic key_q;
   // contacts and receiver report plain levels
   assign o_tag_present = i_tag;
   assign o_door_open = i_door;
   assign o_motion_detector = i_motion;
   // one pulse per code entry, however long the request is held
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         key_q <= 1'b0;
         o_key_valid <= 1'b0;
      end else begin
         key_q <= i_key_req;
         o_key_valid <= i_key_req & ~key_q;
      end
   end
endmodule // zea_zone_model

// *** tb/tb_zone_egress_alarm_controller.sv ***
// self-checking bench for the zone egress alarm controller
`timescale 1ns/1ps
`define CHK(g, e) cmp(8'(g), 8'(e))
module tb_zone_egress_alarm_controller;
   // ****************************************
   // signals
   // ****************************************
   localparam int TK = 10;
   logic i_clk, i_nrst, i_wr, i_rd, i_lock_obstructed, i_elev_door_open, i_auto_clear_strap;
   logic i_fault_wiring, i_fault_antenna, i_fault_rx, i_band_report;
   logic tag, door, motion, key_req, tag_w, door_w, motion_w, key_w;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata;
   logic o_lock, o_call_inhibit, o_hold_door, o_audible, o_visual, o_egress_alarm;
   logic o_loiter_alarm, o_ajar_alarm, o_super_alarm, o_band_alarm, o_irq;
   logic [31:0] rnd;
   logic [7:0] exp_rst [10];
   int failures, check_count, cyc;
   zea_zone_model zone (.i_clk(i_clk), .i_nrst(i_nrst), .i_tag(tag), .i_door(door), .i_motion(motion),
      .i_key_req(key_req), .o_tag_present(tag_w), .o_door_open(door_w), .o_motion_detector(motion_w),
      .o_key_valid(key_w));
   zea_ctrl #(.TICK_CYCLES(TK)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tag_present(tag_w), .i_door_open(door_w),
      .i_motion_detector(motion_w), .i_lock_obstructed(i_lock_obstructed), .i_elev_door_open(i_elev_door_open),
      .i_key_valid(key_w), .i_auto_clear_strap(i_auto_clear_strap), .i_fault_wiring(i_fault_wiring),
      .i_fault_antenna(i_fault_antenna), .i_fault_rx(i_fault_rx), .i_band_report(i_band_report),
      .o_lock(o_lock), .o_call_inhibit(o_call_inhibit), .o_hold_door(o_hold_door), .o_audible(o_audible),
      .o_visual(o_visual), .o_egress_alarm(o_egress_alarm), .o_loiter_alarm(o_loiter_alarm),
      .o_ajar_alarm(o_ajar_alarm), .o_super_alarm(o_super_alarm), .o_band_alarm(o_band_alarm), .o_irq(o_irq));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // checks read the pre-edge values, so every registered output is settled
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wt(1);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      wt(1);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wt(1);
      i_rd <= 1'b1;
      i_addr <= a;
      wt(1);
      i_rd <= 1'b0;
      wt(1);
      `CHK(o_rdata, e);
   endtask
   task automatic key();
      wt(1);
      key_req <= 1'b1;
      wt(1);
      key_req <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // the whole run needs about 780 cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         close_out();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {i_nrst, i_wr, i_rd, i_lock_obstructed, i_elev_door_open, i_auto_clear_strap} = '0;
      {i_fault_wiring, i_fault_antenna, i_fault_rx, i_band_report, tag, door, motion, key_req} = '0;
      i_addr = '0;
      i_wdata = '0;
      rnd = 32'h3E32;
      exp_rst = '{8'h04, 8'h05, 8'h1E, 8'h0F, 8'h0F, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00};
      wt(12);
      i_nrst <= 1'b1;
      wr(zea_pkg::A_STATE, 8'hFF);
      for (int a = 0; a < 10; a++) rd(4'(a), exp_rst[a]);
      wr(zea_pkg::A_ESCORT, 8'h02);
      // lock hold and delayed release
      i_lock_obstructed <= 1'b1;
      tag <= 1'b1;
      wt(4);
      `CHK(o_lock, 0);
      tag <= 1'b0;
      i_lock_obstructed <= 1'b0;
      wt(4);
      tag <= 1'b1;
      wt(24);
      `CHK(o_lock, 1);
      tag <= 1'b0;
      wt(30);
      `CHK(o_lock, 1);
      wt(35);
      `CHK(o_lock, 0);
      // egress alarm latch and clear; door opened before the tag arrives
      door <= 1'b1;
      wt(4);
      `CHK(o_egress_alarm, 0);
      tag <= 1'b1;
      wt(4);
      `CHK(o_egress_alarm, 1);
      {tag, door} <= 2'b00;
      wt(4);
      `CHK(o_egress_alarm, 1);
      door <= 1'b1;
      key();
      wt(4);
      `CHK(o_egress_alarm, 1);
      wt(25);
      door <= 1'b0;
      key();
      wt(4);
      `CHK(o_egress_alarm, 0);
      wt(25);
      // escort window
      key();
      wt(2);
      {tag, door} <= 2'b11;
      wt(4);
      `CHK({o_egress_alarm, o_lock, o_audible}, 0);
      wt(30);
      `CHK(o_egress_alarm, 1);
      {tag, door} <= 2'b00;
      key();
      wt(30);
      // loiter, time below range clamps to the minimum
      wr(zea_pkg::A_CTRL, 8'h0C);
      wr(zea_pkg::A_LOITER, 8'h05);
      // idle timers reload on the next edge, so the new time must settle before the tag arrives
      wt(1);
      tag <= 1'b1;
      wt(80);
      `CHK(o_loiter_alarm, 0);
      wt(35);
      `CHK(o_loiter_alarm, 1);
      i_auto_clear_strap <= 1'b1;
      wt(4);
      `CHK(o_loiter_alarm, 1);
      tag <= 1'b0;
      wt(4);
      `CHK(o_loiter_alarm, 0);
      i_auto_clear_strap <= 1'b0;
      // door ajar, immediate setting
      wr(zea_pkg::A_CTRL, 8'h14);
      wr(zea_pkg::A_AJAR, 8'h00);
      wt(1);
      door <= 1'b1;
      wt(6);
      `CHK(o_ajar_alarm, 1);
      key();
      wt(25);
      `CHK(o_ajar_alarm, 1);
      door <= 1'b0;
      wt(4);
      `CHK(o_ajar_alarm, 1);
      key();
      wt(4);
      `CHK(o_ajar_alarm, 0);
      wt(25);
      // elevator zone
      wr(zea_pkg::A_CTRL, 8'h21);
      tag <= 1'b1;
      wt(3);
      `CHK(o_call_inhibit, 1);
      i_elev_door_open <= 1'b1;
      wt(4);
      `CHK(o_hold_door, 1);
      tag <= 1'b0;
      wt(3);
      `CHK(o_call_inhibit, 0);
      i_elev_door_open <= 1'b0;
      wt(4);
      `CHK(o_hold_door, 1);
      key();
      wt(4);
      `CHK(o_hold_door, 0);
      wt(25);
      // hallway zone
      wr(zea_pkg::A_CTRL, 8'h42);
      tag <= 1'b1;
      wt(4);
      `CHK({o_audible, o_visual}, 0);
      motion <= 1'b1;
      wt(4);
      `CHK({o_audible, o_visual}, 3);
      `CHK(o_lock, 1);
      {tag, motion} <= 2'b00;
      key();
      wt(4);
      `CHK({o_audible, o_visual}, 0);
      wt(25);
      // supervision and receiver silence
      wr(zea_pkg::A_SUPV, 8'h02);
      i_fault_wiring <= 1'b1;
      wt(3);
      `CHK(o_super_alarm, 1);
      i_fault_wiring <= 1'b0;
      i_fault_rx <= 1'b1;
      wt(3);
      `CHK(o_super_alarm, 1);
      key();
      wt(4);
      `CHK(o_super_alarm, 0);
      wt(35);
      `CHK(o_super_alarm, 1);
      i_fault_rx <= 1'b0;
      // random band and antenna traffic
      repeat (40) begin
         rnd = lfsr(rnd);
         i_band_report <= rnd[0];
         i_fault_antenna <= rnd[1];
         wt(3);
         `CHK(o_band_alarm, rnd[0]);
         `CHK(o_super_alarm, rnd[1]);
      end
      // event status, mask and level interrupt
      {i_band_report, i_fault_antenna} <= 2'b00;
      wr(zea_pkg::A_IRQ_MASK, 8'h3F);
      wr(zea_pkg::A_IRQ_STAT, 8'h3F);
      rd(zea_pkg::A_IRQ_STAT, 8'h00);
      `CHK(o_irq, 0);
      i_band_report <= 1'b1;
      wt(4);
      `CHK(o_irq, 1);
      rd(zea_pkg::A_IRQ_STAT, 8'h10);
      wr(zea_pkg::A_IRQ_MASK, 8'h00);
      wt(3);
      `CHK(o_irq, 0);
      wr(zea_pkg::A_IRQ_MASK, 8'h10);
      wt(3);
      `CHK(o_irq, 1);
      wr(zea_pkg::A_IRQ_STAT, 8'h10);
      wt(3);
      `CHK(o_irq, 0);
      close_out();
   end
endmodule // tb_zone_egress_alarm_controller
